// ### design/mmw_slave.sv
// Two-wire write slave with timed write cycle and paged memory.
`timescale 1ns/1ps
`default_nettype none
module mmw_slave
(
	// System clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Two-wire bus; the serial clock clocks the link logic
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// Module status
	input wire logic i_flags_pending,
	output logic o_interrupt_out_n,
	output logic o_write_busy,
	output logic [7:0] o_page_sel
);
	import mmw_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_LOC = 3'b010,
		ST_DATA = 3'b011,
		ST_SKIP = 3'b100
	} mmw_state_t;

	//------------------------------------------------------------------
	// Link domain: START and STOP detection
	//------------------------------------------------------------------
	// START and STOP are SDA edges while SCL is high, so they are caught
	// on SDA edges; the serial clock stops between frames.
	logic start_tgl_reg;
	always_ff @(negedge i_sda or negedge i_rst_n)
		if (!i_rst_n)
			start_tgl_reg <= 1'b0;
		else if (i_scl)
			start_tgl_reg <= ~start_tgl_reg;

	logic start_seen_reg;
	logic busy_l1_reg;
	logic busy_l2_reg;
	mmw_state_t state_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic [7:0] loc_reg;
	logic [2:0] count_reg;
	logic [31:0] data_reg;
	logic ack_reg;
	logic commit_tgl_reg;
	logic started_reg;
	logic [7:0] rx_byte;
	assign rx_byte = {shift_reg[6:0], i_sda};

	// Busy level from the system domain, two flops on SCL.
	always_ff @(posedge i_scl or negedge i_rst_n)
		if (!i_rst_n)
		begin
			busy_l1_reg <= 1'b0;
			busy_l2_reg <= 1'b0;
		end
		else
		begin
			busy_l1_reg <= o_write_busy;
			busy_l2_reg <= busy_l1_reg;
		end

	// A frame begins when the start toggle differs from the last one seen.
	always_ff @(posedge i_scl or negedge i_rst_n)
		if (!i_rst_n)
			start_seen_reg <= 1'b0;
		else
			start_seen_reg <= start_tgl_reg;
	assign started_reg = start_seen_reg != start_tgl_reg;

	//------------------------------------------------------------------
	// Link domain: byte receiver
	//------------------------------------------------------------------
	always_ff @(posedge i_scl or negedge i_rst_n)
		if (!i_rst_n)
		begin
			state_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			loc_reg <= 8'h00;
			count_reg <= 3'h0;
			data_reg <= 32'h0;
		end
		else if (started_reg)
		begin
			// A new START drops any pending burst.
			state_reg <= ST_ADDR; // RQ4 RQ7 RQ10
			bit_reg <= 4'h1;
			shift_reg <= {7'h00, i_sda};
			count_reg <= 3'h0; // RQ4
		end
		else if (bit_reg == 4'h8)
		begin
			bit_reg <= 4'h0; // acknowledge slot
		end
		else
		begin
			bit_reg <= bit_reg + 4'h1;
			shift_reg <= rx_byte;
			if (bit_reg == 4'h7)
			begin
				case (state_reg)
				ST_ADDR:
					// Busy device ignores its address: ack polling.
					if (rx_byte == {SLAVE_ADDR, 1'b0} && !busy_l2_reg) // RQ1 RQ6 RQ11 RQ16
						state_reg <= ST_LOC;
					else
						state_reg <= ST_SKIP; // RQ18
				ST_LOC:
				begin
					loc_reg <= rx_byte; // RQ1
					state_reg <= ST_DATA;
				end
				ST_DATA:
					if (count_reg < 3'(MAX_BURST)) // RQ8 RQ9
					begin
						data_reg[count_reg*8 +: 8] <= rx_byte;
						count_reg <= count_reg + 3'h1;
					end
					else
						state_reg <= ST_SKIP;
				default:
					state_reg <= ST_SKIP;
				endcase
			end
		end

	// Acknowledge driven from SCL fall, for the ninth clock of a byte.
	always_ff @(negedge i_scl or negedge i_rst_n)
		if (!i_rst_n)
			ack_reg <= 1'b0;
		else
			ack_reg <= bit_reg == 4'h8 && state_reg != ST_IDLE && state_reg != ST_SKIP && !(state_reg == ST_DATA && count_reg == 3'h0 && 1'b0); // RQ2 RQ9
	assign o_sda = 1'b0;
	assign o_sda_oe = ack_reg;

	// STOP commits the captured burst by a toggle to the system side.
	always_ff @(posedge i_sda or negedge i_rst_n)
		if (!i_rst_n)
			commit_tgl_reg <= 1'b0;
		else if (i_scl && state_reg == ST_DATA && count_reg != 3'h0 && !started_reg)
			commit_tgl_reg <= ~commit_tgl_reg; // RQ3 RQ5

	//------------------------------------------------------------------
	// System domain: internal write cycle and memory
	//------------------------------------------------------------------
	logic [2:0] cm_sync_reg;
	logic [12:0] wr_cnt_reg;
	logic [7:0] mem_reg [0:127];
	logic [7:0] up_reg [0:3][0:127];
	mmw_burst_t burst;
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
			cm_sync_reg <= 3'h0;
		else
			cm_sync_reg <= {cm_sync_reg[1:0], commit_tgl_reg};

	// The burst is copied once the commit toggle has crossed, because an
	// ack poll during the write cycle clears the link-side byte count.
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
			burst <= '0;
		else if (cm_sync_reg[2] != cm_sync_reg[1])
			burst <= '{loc: loc_reg, count: count_reg, data: data_reg}; // RQ5
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
			wr_cnt_reg <= 13'h0;
		else if (cm_sync_reg[2] != cm_sync_reg[1])
			wr_cnt_reg <= 13'(WR_CYCLES); // RQ5
		else if (wr_cnt_reg != 13'h0)
			wr_cnt_reg <= wr_cnt_reg - 13'h1;
	assign o_write_busy = wr_cnt_reg != 13'h0; // RQ6

	logic commit;
	assign commit = wr_cnt_reg == 13'h1;
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
		begin
			o_page_sel <= PAGE_RESET;
			for (int i = 0; i < 128; i++)
				mem_reg[i] <= 8'h00; // RQ20
		end
		else if (commit)
			for (int k = 0; k < MAX_BURST; k++)
				if (3'(k) < burst.count)
				begin
					logic [7:0] a;
					a = burst.loc + 8'(k); // RQ21
					if (!a[7])
					begin
						if (a == PAGE_SEL_LOC)
							o_page_sel <= burst.data[k*8 +: 8]; // RQ19
						else if (a != STATUS_LOC)
							mem_reg[a[6:0]] <= burst.data[k*8 +: 8]; // RQ12
					end
				end

	// Upper pages 00 to 03; writes land in the selected page if present.
	always_ff @(posedge i_clock)
		if (commit)
			for (int k = 0; k < MAX_BURST; k++)
				if (3'(k) < burst.count)
				begin
					logic [7:0] a;
					a = burst.loc + 8'(k);
					if (a[7] && o_page_sel < 8'h04) // RQ13 RQ15
						if (o_page_sel != 8'h03 || !STATUS_RESET[FLAT_NO_P3_BIT]) // RQ14
							up_reg[o_page_sel[1:0]][a[6:0]] <= burst.data[k*8 +: 8];
				end

	assign o_interrupt_out_n = ~i_flags_pending; // RQ17
endmodule // mmw_slave
`default_nettype wire

// ### design/mmw_pkg.sv
// Package for the module management serial write and paging slave.
//------------------------------------------------------------------
// Functional notes
// RQ1 - Write is address byte then location byte
// RQ2 - Acknowledge location, then take and acknowledge data
// RQ3 - Host ends every write with STOP
// RQ4 - Repeated START aborts write, data discarded
// RQ5 - STOP starts timed write, input ignored
// RQ6 - No acknowledge while write cycle runs
// RQ7 - Combined format writes never committed
// RQ8 - Accept up to four sequential bytes
// RQ9 - Acknowledge every data byte, three extra max
// RQ10 - Sequential write without STOP is discarded
// RQ11 - Address acknowledged only after write completes
// RQ12 - Lower page 128 bytes plus selectable uppers
// RQ13 - Lower page and upper page 00 always
// RQ14 - Page 03 present when byte 2 bit 2 low
// RQ15 - Page 02 user storage, page 01 table
// RQ16 - Single slave address A0 hex
// RQ17 - Host reads flags after interrupt asserts
// RQ18 - Read address is write address plus one; here A1 hex goes to ST_SKIP, unacknowledged, as no reads exist
// RQ19 - Location 127 selects upper page
// RQ20 - Reserved bits read as zero
// RQ21 - Location counter advances per data byte
//------------------------------------------------------------------
package mmw_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h50;
	localparam int MAX_BURST = 4;
	localparam logic [7:0] PAGE_SEL_LOC = 8'h7f;
	localparam logic [7:0] STATUS_LOC = 8'h02;
	localparam int FLAT_NO_P3_BIT = 2;
	localparam int WR_TIME_US = 40;
	localparam int CLK_MHZ = 100;
	localparam int WR_CYCLES = WR_TIME_US * CLK_MHZ;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	typedef struct packed {
		logic [7:0] loc;
		logic [2:0] count;
		logic [31:0] data;
	} mmw_burst_t;
endpackage

// ### verif/mmw_host.sv
// Host model that masters the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module mmw_host
(
	// Bus side
	output logic o_scl,
	output logic o_pull,
	input wire logic i_sda
);
	// The serial clock stands high between frames.
	initial
	begin
		o_scl = 1'b1;
		o_pull = 1'b0;
	end
	// Data only moves while the clock is low.
	task automatic sbit(input logic b, output logic r);
		o_pull = ~b;
		#20 o_scl = 1'b1;
		#20 r = i_sda;
		#20 o_scl = 1'b0;
		#20;
	endtask
	task automatic start;
		o_pull = 1'b0;
		#20 o_scl = 1'b1;
		#20 o_pull = 1'b1;
		#20 o_scl = 1'b0;
		#20;
	endtask
	task automatic stop;
		o_pull = 1'b1;
		#20 o_scl = 1'b1;
		#20 o_pull = 1'b0;
		#40;
	endtask
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			sbit(v[i], r);
		sbit(1'b1, r);
		ack = ~r;
	endtask
endmodule // mmw_host
`default_nettype wire

// ### verif/mmw_chk.sv
// Port checker for the write slave.
`timescale 1ns/1ps
`default_nettype none
module mmw_chk
	import mmw_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_flags_pending,
	input wire logic o_interrupt_out_n,
	input wire logic o_write_busy,
	input wire logic [7:0] o_page_sel
);
	logic [12:0] busy_cnt;
	logic [12:0] since_stop;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
			busy_cnt <= 13'h0;
		else
			busy_cnt <= o_write_busy ? busy_cnt + 13'h1 : 13'h0;
	// Saturates so a write cycle long after any STOP is still caught.
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
			since_stop <= 13'h1fff;
		else if (i_scl && $rose(i_sda))
			since_stop <= 13'h0;
		else if (since_stop != 13'h1fff)
			since_stop <= since_stop + 13'h1;
	sequence ack_held;
		o_sda_oe [*4];
	endsequence
	ack_hold_a: assert property ($rose(o_sda_oe) |-> ack_held)
		else $error("ack released early");
	busy_quiet_a: assert property (o_write_busy |-> !o_sda_oe)
		else $error("ack during write cycle");
	busy_len_a: assert property ($fell(o_write_busy) |->
		busy_cnt == 13'(WR_CYCLES))
		else $error("write cycle length wrong");
	busy_cause_a: assert property ($rose(o_write_busy) |->
		since_stop < 13'h28)
		else $error("write cycle without stop");
	page_cause_a: assert property ($changed(o_page_sel) |->
		since_stop < 13'h1100)
		else $error("page changed without stop");
	irq_follow_a: assert property (o_interrupt_out_n == !i_flags_pending)
		else $error("interrupt output wrong");
	sda_low_a: assert property (o_sda == 1'b0)
		else $error("data output not low");
	reset_val_a: assert property ($rose(i_rst_n) |-> !o_write_busy &&
		!o_sda_oe && o_page_sel == PAGE_RESET)
		else $error("reset values wrong");
endmodule // mmw_chk
`default_nettype wire

// ### verif/mmw_slave_bench.sv
// Bench for the write slave with a host model on the bus.
`timescale 1ns/1ps
`default_nettype none
module mmw_slave_bench;
	import mmw_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_flags_pending = 1'b0;
	logic scl, pull, sda_oe, sda_out, busy, irq_n;
	logic [7:0] page;
	wire logic sda_line;
	int miscompares = 0;
	int total_checks = 0;
	// Pulled-up line: low while either side pulls it.
	assign sda_line = !(pull || sda_oe);
	always #5 i_clock = ~i_clock;
	mmw_host u_mmw_host (.o_scl(scl), .o_pull(pull), .i_sda(sda_line));
	mmw_slave u_mmw_slave (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_scl(scl), .i_sda(sda_line), .o_sda(sda_out), .o_sda_oe(sda_oe),
		.i_flags_pending(i_flags_pending), .o_interrupt_out_n(irq_n),
		.o_write_busy(busy), .o_page_sel(page));
	task automatic check(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Offset keeps serial edges clear of system clock edges.
	task automatic poll(output logic a);
		@(posedge i_clock);
		#3;
		u_mmw_host.start();
		u_mmw_host.put(8'ha0, a);
		u_mmw_host.stop();
	endtask
	task automatic wr(input logic [7:0] loc, input int n,
		input logic [31:0] d, input logic fin);
		logic a;
		@(posedge i_clock);
		#3;
		u_mmw_host.start();
		u_mmw_host.put(8'ha0, a);
		check(a, "address refused");
		u_mmw_host.put(loc, a);
		check(a, "location refused");
		for (int i = 0; i < n; i++)
		begin
			u_mmw_host.put(d[31-8*i -: 8], a);
			check(a, "data refused");
		end
		if (!fin)
			u_mmw_host.start();
		u_mmw_host.stop();
	endtask
	task automatic commit(input logic [7:0] exp);
		int k = 0;
		logic a;
		while (busy !== 1'b1 && k < 40)
		begin
			@(posedge i_clock);
			k++;
		end
		check(busy, "no write cycle");
		poll(a);
		check(!a, "acked while busy");
		while (busy === 1'b1 && k < 6000)
		begin
			@(posedge i_clock);
			k++;
		end
		poll(a);
		check(a, "no ack after write");
		check(page === exp, "page select wrong");
	endtask
	task automatic nocommit(input logic [7:0] exp);
		repeat (50) @(posedge i_clock);
		check(busy === 1'b0 && page === exp, "aborted write kept");
	endtask
	initial
	begin
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		wr(8'h7f, 1, 32'h03000000, 1'b1);
		commit(8'h03);
		wr(8'h7f, 1, 32'h05000000, 1'b0);
		nocommit(8'h03);
		wr(8'h7c, 4, 32'h11223301, 1'b1);
		commit(8'h01);
		wr(8'h7e, 2, 32'h09020000, 1'b0);
		nocommit(8'h01);
		i_flags_pending <= 1'b1;
		repeat (2) @(posedge i_clock);
		check(irq_n === 1'b0, "interrupt not low");
		finish_test();
	end
	initial
	begin
		#400000;
		miscompares++;
		finish_test();
	end
endmodule // mmw_slave_bench
bind mmw_slave mmw_chk u_mmw_chk (.i_clock, .i_rst_n, .i_scl, .i_sda,
	.o_sda, .o_sda_oe, .i_flags_pending, .o_interrupt_out_n,
	.o_write_busy, .o_page_sel);
`default_nettype wire
